// ==== dv/tb_tap_and_staging_config_bank.sv ====
// Self-checking testbench for the tap and staging register bank
`timescale 1ns/100ps

`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end

module tb_tap_and_staging_config_bank;

  // ==========================================================
  // Signals and tables
  // ==========================================================
  logic        clk, rst_b, clk_en;   // Clock, reset, enable
  logic        reg_wr, reg_rd;       // Strobes from the master
  logic [15:0] reg_addr, reg_wdata;  // Address and write data
  logic [15:0] reg_rdata;            // Read data
  logic        reg_rvalid;           // Read data valid
  logic        reg_wrange;           // Out-of-range flag
  logic        hw_en, hw_first;      // Hot-water loop controls
  logic        sh_first;             // Heating loop first
  logic        add_en, drop_en;      // Staging enables
  int          n_fail, num_checks;   // Mismatch and check counters
  logic [15:0] rdat;                 // Word read back
  logic        vld, flag;            // Valid and range flags seen

  // Mapped addresses, reset values, legal end values and first illegal values
  localparam logic [15:0] ADR [0:19] = '{16'h02B8, 16'h02B9, 16'h02BA,
    16'h02BB, 16'h02BC, 16'h02BD, 16'h02BE, 16'h02C0, 16'h02C1, 16'h02C2,
    16'h02C9, 16'h02CA, 16'h02CC, 16'h02CE, 16'h02CF, 16'h02D0, 16'h02D1,
    16'h02D2, 16'h02D3, 16'h02D5};
  localparam logic [15:0] RST [0:19] = '{16'hFFFF, 16'h0000, 16'h0000,
    16'h0FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hFFFF, 16'h0000, 16'hFFFF};
  localparam logic [15:0] LEG [0:19] = '{16'hFD20, 16'h0514, 16'h0514,
    16'hFD20, 16'h0514, 16'h0514, 16'h0514, 16'h0003, 16'hFE70, 16'h0001,
    16'h0003, 16'h0004, 16'hFFFF, 16'h0514, 16'hFC18, 16'h0064, 16'h0064,
    16'hFD20, 16'h0004, 16'hFD20};
  localparam logic [15:0] BAD [0:19] = '{16'hFD21, 16'h0515, 16'h0515,
    16'hFD21, 16'h0515, 16'h0515, 16'h0515, 16'h0004, 16'hFE6F, 16'h0002,
    16'h0004, 16'h0005, 16'hFD21, 16'h0515, 16'h03E9, 16'h0065, 16'h0065,
    16'hFD21, 16'h0005, 16'hFD21};
  // Reserved holes plus one address far outside the range
  localparam logic [15:0] RSV [0:7] = '{16'h02BF, 16'h02C3, 16'h02C8,
    16'h02CB, 16'h02CD, 16'h02D4, 16'h02D6, 16'h0000};

  // ==========================================================
  // Clock, design and master
  // ==========================================================
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tscb_bank uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_wrange(reg_wrange), .hot_water_loop_en(hw_en),
    .hot_water_loop_first(hw_first), .space_heating_loop_first(sh_first),
    .add_stage_en(add_en), .drop_stage_en(drop_en));

  tscb_master m (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wrange(reg_wrange));

  // ==========================================================
  // Closing report
  // ==========================================================
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Write then let the decoded outputs settle one edge later
  task automatic ctl(input logic [15:0] a, input logic [15:0] v);
    m.wr(a, v, flag);
    @(posedge clk);
    #1;
  endtask : ctl

  // Watchdog: the run is short, so a hang ends as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    n_fail = 0;
    num_checks = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values and not-configured markers
    for (int i = 0; i < 20; i++) begin
      m.rd(ADR[i], rdat, vld);
      `CHK("reset value", RST[i], rdat);
    end
    // Boundary writes one idle cycle apart: flagged out of range, then legal
    for (int i = 0; i < 20; i++) begin
      m.wr(ADR[i], BAD[i], flag);
      `CHK("range flag high", 1'b1, flag);
      m.wr(ADR[i], LEG[i], flag);
      `CHK("range flag low", 1'b0, flag);
      m.rd(ADR[i], rdat, vld);
      `CHK("read valid", 1'b1, vld);
      `CHK("read back", LEG[i], rdat);
    end
    // Holes hold nothing and give no indication on write
    for (int i = 0; i < 8; i++) begin
      m.wr(RSV[i], 16'hFFFF, flag);
      `CHK("hole flag", 1'b0, flag);
      m.rd(RSV[i], rdat, vld);
      `CHK("hole read", 16'h0000, rdat);
    end
    // Every demand source code
    for (int v = 0; v < 4; v++) begin
      ctl(16'h02C0, 16'(v));
      `CHK("loop enable", (v != 0), hw_en);
    end
    // Both priority settings
    for (int v = 0; v < 2; v++) begin
      ctl(16'h02C2, 16'(v));
      `CHK("hot water first", (v == 1), hw_first);
      `CHK("heating first", (v == 0), sh_first);
    end
    // Every add and drop method code
    for (int v = 0; v < 5; v++) begin
      ctl(16'h02CA, 16'(v));
      `CHK("add enable", (v != 0), add_en);
      ctl(16'h02D3, 16'(v));
      `CHK("drop enable", (v != 0), drop_en);
    end
    // Frozen clock enable swallows a read
    @(posedge clk);
    clk_en <= 1'b0;
    m.rd(16'h02B8, rdat, vld);
    `CHK("frozen valid", 1'b0, vld);
    @(posedge clk);
    clk_en <= 1'b1;
    m.rd(16'h02B8, rdat, vld);
    `CHK("after freeze", 16'hFD20, rdat);
    // Not-configured markers accepted; write and read back to back
    m.wr(16'h02BB, 16'h0FFF, flag);
    `CHK("short marker flag", 1'b0, flag);
    m.wr_rd(16'h02B8, 16'hFFFF, flag, rdat);
    `CHK("full marker flag", 1'b0, flag);
    `CHK("back to back read", 16'hFFFF, rdat);
    // Mid-run reset brings settings and decoded outputs back
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset heating first", 1'b1, sh_first);
    `CHK("reset loop enable", 1'b0, hw_en);
    `CHK("reset add enable", 1'b0, add_en);
    @(posedge clk);
    rst_b <= 1'b1;
    m.rd(16'h02C0, rdat, vld);
    `CHK("reset source", 16'h0000, rdat);
    test_done();
  end

endmodule : tb_tap_and_staging_config_bank

// ==== dv/tscb_master.sv ====
// Behavioural register-access master facing the configuration bank
`timescale 1ns/100ps

module tscb_master (
  input  wire logic        clk,        // Bank clock
  output logic             reg_wr,     // Write strobe
  output logic             reg_rd,     // Read strobe
  output logic      [15:0] reg_addr,   // Word address
  output logic      [15:0] reg_wdata,  // Write data
  input  wire logic [15:0] reg_rdata,  // Read data
  input  wire logic        reg_rvalid, // Read data valid
  input  wire logic        reg_wrange  // Out-of-range flag
);

  // ==========================================================
  // Idle bus
  // ==========================================================
  // Bus idles with no strobe, before reset is released
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // ==========================================================
  // Access tasks
  // ==========================================================
  // whole words
  // One 16-bit word a write; address and data are inverted once released
  // so that a stale value on the bus can never pass for a fresh one
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    output logic flag);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
    flag = reg_wrange;
  endtask : wr

  // Read answer stands one cycle, so it is taken just after that edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d,
                    output logic vld);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d   = reg_rdata;
    vld = reg_rvalid;
  endtask : rd

  // Write, then read the same word on the very next edge: the bank
  // must already answer with the word that was just written
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d,
                       output logic flag, output logic [15:0] q);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    #1;
    flag = reg_wrange;
    @(posedge clk);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
  endtask : wr_rd

endmodule : tscb_master

// ==== hdl/tscb_bank.sv ====
// Register bank for tap detection, preheat and lead/lag staging settings
`timescale 1ns/100ps
// Notes on behaviour
// - Recognition time up to 64800, FFFF unset
// - Hot-water-inlet stop delta, 0 to 130.0
// - Outlet-inlet stop delta, 0 to 130.0
// - Minimum on-time up to 64800, FFF unset
// - Tap and preheat thresholds 0 to 130.0
// - Demand source: off, thermostat, reserved, bus
// - Staged setpoint from -40.0 to 130.0
// - Priority: 0 heating first, 1 hot water
// - Slave compensation: none, replace, adjust, both
// - Add method: five encodings, zero never adds
// - Add detect time up to 64800, FFFF unset
// - Add error threshold 0 to 130.0
// - Add rate offset signed -100.0 to 100.0
// - Add error and rate gains 0 to 100
// - Inter-stage delay up to 64800, FFFF unset
// - Drop method uses same five encodings
// - Drop detect time up to 64800, FFFF unset

module tscb_bank (
  input  wire logic        clk,           // 25 MHz clock
  input  wire logic        rst_b,         // Async reset, active low
  input  wire logic        clk_en,        // Freezes all state when low
  input  wire logic        reg_wr,        // Register write strobe
  input  wire logic        reg_rd,        // Register read strobe
  input  wire logic [15:0] reg_addr,      // Register address
  input  wire logic [15:0] reg_wdata,     // Write data
  output logic      [15:0] reg_rdata,     // Read data, registered
  output logic             reg_rvalid,    // Read data valid pulse
  output logic             reg_wrange,    // Write value outside range
  output logic             hot_water_loop_en,    // Hot-water loop enabled
  output logic             hot_water_loop_first, // Hot water has priority
  output logic             space_heating_loop_first, // Heating first
  output logic             add_stage_en,  // Add-stage method not never
  output logic             drop_stage_en  // Drop-stage method not never
);

  // ==========================================================
  // Storage
  // ==========================================================
  localparam int unsigned NREG = 20;  // Number of stored settings

  logic [15:0] regs_q [NREG];         // Setting words
  logic [4:0]  wr_idx;                // Decoded index of access
  logic        hit;                   // Address maps to a setting
  logic        legal;                 // Write value is in range

  // Map an address to a storage slot; reserved holes do not hit
  function automatic logic [5:0] decode(input logic [15:0] a);
    unique case (a)
      tscb_pkg::ADDR_TAP_RECOG_TIME:     decode = {1'b1, 5'd0};
      tscb_pkg::ADDR_TAP_STOP_HW_DELTA:  decode = {1'b1, 5'd1};
      tscb_pkg::ADDR_TAP_STOP_OI_DELTA:  decode = {1'b1, 5'd2};
      tscb_pkg::ADDR_TAP_MIN_ON_TIME:    decode = {1'b1, 5'd3};
      tscb_pkg::ADDR_TAP_ON_THRESH:      decode = {1'b1, 5'd4};
      tscb_pkg::ADDR_PREHEAT_ON_THRESH:  decode = {1'b1, 5'd5};
      tscb_pkg::ADDR_PREHEAT_OFF_THRESH: decode = {1'b1, 5'd6};
      tscb_pkg::ADDR_HW_DEMAND_SOURCE:   decode = {1'b1, 5'd7};
      tscb_pkg::ADDR_STAGED_HW_SETPOINT: decode = {1'b1, 5'd8};
      tscb_pkg::ADDR_HW_PRIORITY:        decode = {1'b1, 5'd9};
      tscb_pkg::ADDR_SLAVE_COMP_MODE:    decode = {1'b1, 5'd10};
      tscb_pkg::ADDR_ADD_METHOD:         decode = {1'b1, 5'd11};
      tscb_pkg::ADDR_ADD_DETECT_TIME:    decode = {1'b1, 5'd12};
      tscb_pkg::ADDR_ADD_ERR_THRESH:     decode = {1'b1, 5'd13};
      tscb_pkg::ADDR_ADD_RATE_OFFSET:    decode = {1'b1, 5'd14};
      tscb_pkg::ADDR_ADD_ERR_GAIN:       decode = {1'b1, 5'd15};
      tscb_pkg::ADDR_ADD_RATE_GAIN:      decode = {1'b1, 5'd16};
      tscb_pkg::ADDR_ADD_INTERSTAGE:     decode = {1'b1, 5'd17};
      tscb_pkg::ADDR_DROP_METHOD:        decode = {1'b1, 5'd18};
      tscb_pkg::ADDR_DROP_DETECT_TIME:   decode = {1'b1, 5'd19};
      // Reserved and outside addresses
      default:                           decode = 6'h00;
    endcase
  endfunction : decode

  // Duration setting: up to 64800 or the given unset marker
  function automatic logic time_ok(input logic [15:0] v,
                                   input logic [15:0] unset);
    time_ok = (v <= tscb_pkg::TIME_MAX_S) || (v == unset);
  endfunction : time_ok

  // Unsigned value up to a limit
  function automatic logic upto(input logic [15:0] v,
                                input logic [15:0] lim);
    upto = (v <= lim);
  endfunction : upto

  // Signed value inside a two-sided window, two's complement
  function automatic logic swin(input logic [15:0] v,
                                input logic [15:0] lo,
                                input logic [15:0] hi);
    swin = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction : swin

  // Address decode for the current access
  always_comb begin
    {hit, wr_idx} = decode(reg_addr);
  end

  // Range check of the write value against its slot
  always_comb begin
    legal = 1'b0;
    unique case (wr_idx)
      5'd0:  legal = time_ok(reg_wdata, tscb_pkg::UNSET_FULL);
      5'd1:  legal = upto(reg_wdata, tscb_pkg::TEMP_MAX);
      5'd2:  legal = upto(reg_wdata, tscb_pkg::TEMP_MAX);
      5'd3:  legal = time_ok(reg_wdata, tscb_pkg::UNSET_SHORT);
      5'd4, 5'd5, 5'd6: legal = upto(reg_wdata, tscb_pkg::TEMP_MAX);
      5'd7:  legal = upto(reg_wdata, tscb_pkg::ENUM2_MAX);
      5'd8:  legal = swin(reg_wdata, tscb_pkg::TEMP_MIN_NEG,
                          tscb_pkg::TEMP_MAX);
      5'd9:  legal = upto(reg_wdata, tscb_pkg::BOOL_MAX);
      5'd10: legal = upto(reg_wdata, tscb_pkg::ENUM2_MAX);
      5'd11: legal = upto(reg_wdata, tscb_pkg::METHOD_MAX);
      5'd12: legal = time_ok(reg_wdata, tscb_pkg::UNSET_FULL);
      5'd13: legal = upto(reg_wdata, tscb_pkg::TEMP_MAX);
      5'd14: legal = swin(reg_wdata, tscb_pkg::PCT_MIN_NEG,
                          tscb_pkg::PCT_MAX);
      5'd15, 5'd16: legal = upto(reg_wdata, tscb_pkg::GAIN_MAX);
      5'd17: legal = time_ok(reg_wdata, tscb_pkg::UNSET_FULL);
      5'd18: legal = upto(reg_wdata, tscb_pkg::METHOD_MAX);
      5'd19: legal = time_ok(reg_wdata, tscb_pkg::UNSET_FULL);
      // Codes 20..31 never decode with hit set
      default: legal = 1'b0;
    endcase
  end

  // ==========================================================
  // Write path
  // ==========================================================
  // Out-of-range values are still stored as written: the master
  // owns range, and refusing silently would hide its mistake.
  // stored as written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= tscb_pkg::RST_TIME;
      end
      // Non-duration settings start at zero
      for (int i = 1; i < 3; i++) begin
        regs_q[i] <= tscb_pkg::RST_ZERO;
      end
      regs_q[3] <= tscb_pkg::RST_SHORT;
      for (int i = 4; i < 12; i++) begin
        regs_q[i] <= tscb_pkg::RST_ZERO;
      end
      for (int i = 13; i < 17; i++) begin
        regs_q[i] <= tscb_pkg::RST_ZERO;
      end
      regs_q[18] <= tscb_pkg::RST_ZERO;
    end else if (clk_en && reg_wr && hit) begin
      regs_q[wr_idx] <= reg_wdata;
    end
  end

  // Flag a write that lands out of range on a mapped slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_wrange <= 1'b0;
    end else if (clk_en) begin
      reg_wrange <= reg_wr && hit && !legal;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // reserved reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= hit ? regs_q[wr_idx] : 16'h0000;
      end
    end
  end

  // ==========================================================
  // Decoded control outputs
  // ==========================================================
  // Registered so the outputs do not glitch on writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hot_water_loop_en        <= 1'b0;
      hot_water_loop_first     <= 1'b0;
      space_heating_loop_first <= 1'b1;
      add_stage_en             <= 1'b0;
      drop_stage_en            <= 1'b0;
    end else if (clk_en) begin
      hot_water_loop_en <= regs_q[7] != 16'h0000;
      hot_water_loop_first     <= regs_q[9] == 16'h0001;
      space_heating_loop_first <= regs_q[9] != 16'h0001;
      add_stage_en  <= regs_q[11] != 16'h0000;
      drop_stage_en <= regs_q[18] != 16'h0000;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_read_req;
    clk_en && reg_rd && !hit;
  endsequence

  a_reserved_read_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_read_req |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("Reserved address did not read zero");

  a_write_read_back: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && hit && !reg_rd ##1
      clk_en && reg_rd && !reg_wr && wr_idx == $past(wr_idx)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Written setting not read back");

  a_short_unset_ok: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_TAP_MIN_ON_TIME &&
      reg_wdata == tscb_pkg::UNSET_SHORT |=> !reg_wrange)
    else $error("Short unset marker flagged");

  a_setpoint_window: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_STAGED_HW_SETPOINT
    |=> reg_wrange == !swin($past(reg_wdata), tscb_pkg::TEMP_MIN_NEG,
                            tscb_pkg::TEMP_MAX))
    else $error("Setpoint window misjudged");

  a_source_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_HW_DEMAND_SOURCE
    ##1 clk_en |=> hot_water_loop_en == ($past(reg_wdata, 2) != 0))
    else $error("Loop enable did not follow source");

  a_priority_excl: assert property (
    @(posedge clk) disable iff (!rst_b)
    hot_water_loop_first != space_heating_loop_first)
    else $error("Priority outputs not exclusive");

  a_add_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_ADD_METHOD
    ##1 clk_en |=> add_stage_en == ($past(reg_wdata, 2) != 0))
    else $error("Add enable did not follow method");

  a_gain_range: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_ADD_ERR_GAIN &&
      reg_wdata > tscb_pkg::GAIN_MAX |=> reg_wrange)
    else $error("Gain over 100 not flagged");

  // Write to one setting, then one more enabled edge for the
  // registered control output to pick the new word up
  sequence s_prio_wr;
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_HW_PRIORITY;
  endsequence

  sequence s_drop_wr;
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_DROP_METHOD;
  endsequence

  a_priority_follow: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_prio_wr ##1 clk_en
    |=> hot_water_loop_first == ($past(reg_wdata, 2) == 16'h0001))
    else $error("Priority output did not follow setting");

  a_drop_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_drop_wr ##1 clk_en |=> drop_stage_en == ($past(reg_wdata, 2) != 0))
    else $error("Drop enable did not follow method");

  a_reserved_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && !hit |=> !reg_wrange)
    else $error("Reserved write raised range flag");

  a_full_unset_ok: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_TAP_RECOG_TIME &&
      reg_wdata == tscb_pkg::UNSET_FULL |=> !reg_wrange)
    else $error("Full unset marker flagged");

  a_delta_limit: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_TAP_STOP_HW_DELTA &&
      reg_wdata > tscb_pkg::TEMP_MAX |=> reg_wrange)
    else $error("Delta over limit not flagged");

  a_method_limit: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_ADD_METHOD &&
      reg_wdata > tscb_pkg::METHOD_MAX |=> reg_wrange)
    else $error("Method code over limit not flagged");

  a_rate_floor: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == tscb_pkg::ADDR_ADD_RATE_OFFSET &&
      reg_wdata == tscb_pkg::PCT_MIN_NEG |=> !reg_wrange)
    else $error("Lowest rate offset flagged");

  a_read_answer: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_rd |=> reg_rvalid)
    else $error("Read strobe got no valid answer");

endmodule : tscb_bank

// ==== hdl/tscb_pkg.sv ====
// Package for the tap and staging configuration register bank
package tscb_pkg;

  // Register word width and register address width
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  // Register addresses
  localparam logic [15:0] ADDR_TAP_RECOG_TIME     = 16'h02B8;
  localparam logic [15:0] ADDR_TAP_STOP_HW_DELTA  = 16'h02B9;
  localparam logic [15:0] ADDR_TAP_STOP_OI_DELTA  = 16'h02BA;
  localparam logic [15:0] ADDR_TAP_MIN_ON_TIME    = 16'h02BB;
  localparam logic [15:0] ADDR_TAP_ON_THRESH      = 16'h02BC;
  localparam logic [15:0] ADDR_PREHEAT_ON_THRESH  = 16'h02BD;
  localparam logic [15:0] ADDR_PREHEAT_OFF_THRESH = 16'h02BE;
  localparam logic [15:0] ADDR_HW_DEMAND_SOURCE   = 16'h02C0;
  localparam logic [15:0] ADDR_STAGED_HW_SETPOINT = 16'h02C1;
  localparam logic [15:0] ADDR_HW_PRIORITY        = 16'h02C2;
  localparam logic [15:0] ADDR_SLAVE_COMP_MODE    = 16'h02C9;
  localparam logic [15:0] ADDR_ADD_METHOD         = 16'h02CA;
  localparam logic [15:0] ADDR_ADD_DETECT_TIME    = 16'h02CC;
  localparam logic [15:0] ADDR_ADD_ERR_THRESH     = 16'h02CE;
  localparam logic [15:0] ADDR_ADD_RATE_OFFSET    = 16'h02CF;
  localparam logic [15:0] ADDR_ADD_ERR_GAIN       = 16'h02D0;
  localparam logic [15:0] ADDR_ADD_RATE_GAIN      = 16'h02D1;
  localparam logic [15:0] ADDR_ADD_INTERSTAGE     = 16'h02D2;
  localparam logic [15:0] ADDR_DROP_METHOD        = 16'h02D3;
  localparam logic [15:0] ADDR_DROP_DETECT_TIME   = 16'h02D5;

  // First and last address of the covered range
  localparam logic [15:0] ADDR_FIRST = 16'h02B8;
  localparam logic [15:0] ADDR_LAST  = 16'h02D6;

  // Not-configured markers
  localparam logic [15:0] UNSET_FULL  = 16'hFFFF;
  localparam logic [15:0] UNSET_SHORT = 16'h0FFF;

  // Range limits
  localparam logic [15:0] TIME_MAX_S   = 16'hFD20;  // 64800 seconds
  localparam logic [15:0] TEMP_MAX     = 16'h0514;  // 130.0 degrees
  localparam logic [15:0] TEMP_MIN_NEG = 16'hFE70;  // -40.0 degrees
  localparam logic [15:0] PCT_MAX      = 16'h03E8;  // +100.0 percent
  localparam logic [15:0] PCT_MIN_NEG  = 16'hFC18;  // -100.0 percent
  localparam logic [15:0] GAIN_MAX     = 16'h0064;  // 100

  // Reset values: settings start not configured or at zero
  localparam logic [15:0] RST_TIME  = 16'hFFFF;
  localparam logic [15:0] RST_SHORT = 16'h0FFF;
  localparam logic [15:0] RST_ZERO  = 16'h0000;

  // Hot-water demand source selections
  typedef enum logic [1:0] {
    TSCB_SRC_OFF,
    TSCB_SRC_THERMOSTAT,
    TSCB_SRC_RESERVED,
    TSCB_SRC_REMOTE_BUS
  } tscb_src_t;

  // Stage add/drop method selections
  typedef enum logic [2:0] {
    TSCB_STG_NEVER,
    TSCB_STG_ERROR,
    TSCB_STG_RATE,
    TSCB_STG_ERROR_ROC,
    TSCB_STG_RATE_ROC
  } tscb_stage_t;

  // Largest legal method code, two-bit selection code and boolean value
  localparam logic [15:0] METHOD_MAX = 16'h0004;
  localparam logic [15:0] ENUM2_MAX  = 16'h0003;
  localparam logic [15:0] BOOL_MAX   = 16'h0001;

endpackage : tscb_pkg
